// ===== core/swc_map.vh
/*
 * Constants of the standby wakeup controller: timing, wake source counts and
 * field layouts.
 * Assumes inclusion by bare name from the controller source.
 */
`ifndef SWC_MAP_VH
`define SWC_MAP_VH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SWC_CLK_PERIOD_PS   10000
`define SWC_EXIT_MAX_NS     60000
`define SWC_CORE_RST_CYC    16

// ----------------------------------------------------------------------
// Wake source counts
// ----------------------------------------------------------------------
`define SWC_EXTI_LINES      16
`define SWC_WAKE_PINS       3

// ----------------------------------------------------------------------
// Oscillator enable vector layout
// ----------------------------------------------------------------------
`define SWC_OSC_PLL         0
`define SWC_OSC_MSI         1
`define SWC_OSC_HSI         2
`define SWC_OSC_HSE         3
`define SWC_OSC_LSI         4
`define SWC_OSC_LSE         5
`define SWC_OSC_W           6
`define SWC_OSC_ALL_ON      6'h3F
`define SWC_OSC_RUN_ON      6'h0F

// ----------------------------------------------------------------------
// Standby wake event vector layout (with the clock in use)
// ----------------------------------------------------------------------
`define SWC_EV_ALARM_A      0
`define SWC_EV_ALARM_B      1
`define SWC_EV_TAMPER       2
`define SWC_EV_TSTAMP       3
`define SWC_EV_CLKWAKE      4
`define SWC_EV_W            5

`endif

// ===== core/swc_ctrl.v
/*
 * Standby wakeup controller: Run, Stop and Standby sequencing, wake source
 * selection, oscillator enables, core power and restart.
 * Assumes all wake sources arrive asynchronously and are synchronised here;
 * the low-power request comes from core logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "swc_map.vh"

module swc_ctrl #(
	parameter EXTI_LINES = `SWC_EXTI_LINES,
	parameter WAKE_PINS  = `SWC_WAKE_PINS
) (
	// Clock and reset
	input  wire                  clk,
	input  wire                  rst_n,
	// Requests from the core, same clock
	input  wire                  stop_req,
	input  wire                  standby_req,
	// Retained configuration
	input  wire                  rtc_in_use,
	input  wire                  rtc_sel_lse,
	input  wire                  independent_watchdog_running,
	input  wire                  vref_on,
	// Asynchronous wake sources
	input  wire [EXTI_LINES-1:0] exti_line,
	input  wire                  supply_voltage_detector,
	input  wire                  comp1_event,
	input  wire                  comp2_event,
	input  wire                  usb_wakeup,
	input  wire [WAKE_PINS-1:0]  wake_pin,
	input  wire                  external_reset_pin_n,
	input  wire                  independent_watchdog_rst,
	input  wire [`SWC_EV_W-1:0]  rtc_event,
	// Power and clock controls
	output reg                   core_regulator_on,
	output reg                   core_reset_n,
	output reg  [`SWC_OSC_W-1:0] osc_enable,
	output reg                   retain_only,
	output reg                   in_stop,
	output reg                   in_standby,
	output reg                   standby_flag,
	output reg                   wake_event
);

	// ------------------------------------------------------------------
	// Derived timing
	// ------------------------------------------------------------------
	localparam integer EXIT_MAX_CYC = (`SWC_EXIT_MAX_NS * 1000) / `SWC_CLK_PERIOD_PS;
	localparam integer RST_CYC      = `SWC_CORE_RST_CYC;
	localparam integer RST_LAST_I   = RST_CYC - 1;
	// Counter compare width is five bits; the cut is deliberate
	localparam [4:0]   RST_LAST     = RST_LAST_I[4:0];

	// One-hot states
	localparam [3:0] ST_RUN   = 4'h1;
	localparam [3:0] ST_STOP  = 4'h2;
	localparam [3:0] ST_STBY  = 4'h4;
	localparam [3:0] ST_RESTR = 4'h8;

	// ------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------
	localparam integer SYNC_W = EXTI_LINES + 4 + WAKE_PINS + 2 + `SWC_EV_W;
	wire [SYNC_W-1:0] async_in;
	reg  [SYNC_W-1:0] sync1_q;
	reg  [SYNC_W-1:0] sync2_q;
	assign async_in = {exti_line, supply_voltage_detector, comp1_event, comp2_event,
		usb_wakeup, wake_pin, ~external_reset_pin_n, independent_watchdog_rst, rtc_event};

	// Two stages; only stage two feeds logic
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_q <= {SYNC_W{1'b0}};
			sync2_q <= {SYNC_W{1'b0}};
		end else begin
			sync1_q <= async_in;
			sync2_q <= sync1_q;
		end
	end

	wire [`SWC_EV_W-1:0]  s_rtc  = sync2_q[`SWC_EV_W-1:0];
	wire                  s_independent_watchdog = sync2_q[`SWC_EV_W];
	wire                  s_external_reset_pin = sync2_q[`SWC_EV_W+1];
	wire [WAKE_PINS-1:0]  s_pin  = sync2_q[`SWC_EV_W+2 +: WAKE_PINS];
	wire [3:0]            s_misc = sync2_q[`SWC_EV_W+2+WAKE_PINS +: 4];
	wire [EXTI_LINES-1:0] s_exti = sync2_q[SYNC_W-1 -: EXTI_LINES];

	// Rising-edge detect on wake pins; the previous value is a stage-three flop
	reg  [WAKE_PINS-1:0] pin_prev_q;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			pin_prev_q <= {WAKE_PINS{1'b0}};
		else
			pin_prev_q <= s_pin;
	end
	wire pin_rise = |(s_pin & ~pin_prev_q);

	// ------------------------------------------------------------------
	// Wake decisions
	// ------------------------------------------------------------------
	// Comparators only count when the reference is on
	wire usb_wake_s = s_misc[0];
	wire stop_wake = (|s_exti) | s_misc[3] | usb_wake_s
		| (vref_on & (s_misc[2] | s_misc[1]));
	wire stby_wake = s_external_reset_pin | pin_rise
		| (rtc_in_use & (s_independent_watchdog | (|s_rtc)));

	// Low-speed enables: the watchdog keeps its own internal source alive
	wire lsi_keep = independent_watchdog_running | (rtc_in_use & ~rtc_sel_lse);
	wire lse_keep = rtc_in_use & rtc_sel_lse;

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	reg [3:0] state_q;
	reg [3:0] state_d;
	reg [4:0] rst_cnt_q;

	// Next-state decode; Standby wins over Stop when both are requested
	always @* begin
		state_d = state_q;
		case (state_q)
		ST_RUN: begin
			if (standby_req)
				state_d = ST_STBY;
			else if (stop_req)
				state_d = ST_STOP;
		end
		ST_STOP: begin
			if (stop_wake | s_external_reset_pin)
				state_d = ST_RUN;
		end
		ST_STBY: begin
			if (stby_wake)
				state_d = ST_RESTR;
		end
		ST_RESTR: begin
			if (rst_cnt_q == RST_LAST)
				state_d = ST_RUN;
		end
		default: state_d = ST_RUN;
		endcase
	end

	// State, restart counter and registered outputs
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q           <= ST_RUN;
			rst_cnt_q         <= 5'h0_0;
			core_regulator_on <= 1'b1;
			core_reset_n      <= 1'b0;
			osc_enable        <= `SWC_OSC_RUN_ON;
			retain_only       <= 1'b0;
			in_stop           <= 1'b0;
			in_standby        <= 1'b0;
			standby_flag      <= 1'b0;
			wake_event        <= 1'b0;
		end else begin
			state_q    <= state_d;
			rst_cnt_q  <= (state_d == ST_RESTR && state_q == ST_RESTR)
				? rst_cnt_q + 5'h0_1 : 5'h0_0;
			in_stop    <= (state_d == ST_STOP);
			in_standby <= (state_d == ST_STBY);
			wake_event <= (state_q == ST_STOP && state_d == ST_RUN)
				| (state_q == ST_STBY && state_d == ST_RESTR);
			// Regulator off for the whole Standby stay, back on to restart
			core_regulator_on <= (state_d != ST_STBY);
			// Core held in reset in Standby and through the restart window
			core_reset_n <= (state_d == ST_RUN) | (state_d == ST_STOP);
			retain_only  <= (state_d == ST_STBY);
			// Retained flag survives the core restart until the next Stop
			if (state_d == ST_STBY)
				standby_flag <= 1'b1;
			else if (state_d == ST_STOP)
				standby_flag <= 1'b0;
			// High-speed sources off in Stop and Standby
			osc_enable[`SWC_OSC_PLL] <= (state_d == ST_RUN) | (state_d == ST_RESTR);
			osc_enable[`SWC_OSC_MSI] <= (state_d == ST_RUN) | (state_d == ST_RESTR);
			osc_enable[`SWC_OSC_HSI] <= (state_d == ST_RUN) | (state_d == ST_RESTR);
			osc_enable[`SWC_OSC_HSE] <= (state_d == ST_RUN) | (state_d == ST_RESTR);
			// Low-speed sources follow the clock and watchdog needs only
			osc_enable[`SWC_OSC_LSI] <= lsi_keep;
			osc_enable[`SWC_OSC_LSE] <= lse_keep;
		end
	end

	// Exit latency: 2 sync + 1 state + RST_CYC (edge detect adds no cycle), far below EXIT_MAX_CYC
	wire unused_ok = (EXIT_MAX_CYC > RST_CYC);

endmodule
`default_nettype wire

// ===== bench/swc_ctrl_assertions.sv
/* Checker of the standby wakeup controller, watching its ports only.
   Assumes one clock and an asynchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
`include "swc_map.vh"
module swc_chk #(
	parameter EXTI_LINES = 16,
	parameter WAKE_PINS  = 3
) (
	// Clock, reset and configuration
	input wire logic                  clk,
	input wire logic                  rst_n,
	input wire logic                  rtc_in_use,
	input wire logic                  rtc_sel_lse,
	input wire logic                  independent_watchdog_running,
	// Wake sources
	input wire logic [EXTI_LINES-1:0] exti_line,
	input wire logic                  external_reset_pin_n,
	input wire logic [WAKE_PINS-1:0]  wake_pin,
	input wire logic [`SWC_EV_W-1:0]  rtc_event,
	// Power and clock controls
	input wire logic                  core_regulator_on,
	input wire logic                  core_reset_n,
	input wire logic [`SWC_OSC_W-1:0] osc_enable,
	input wire logic                  retain_only,
	input wire logic                  in_stop,
	input wire logic                  in_standby
);
	// ------------------------------------------------------------
	// Mode properties; bounds are far inside the 60 us exit budget
	// ------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	stby_entry_a: assert property ($rose(in_standby) |-> !core_regulator_on && !core_reset_n
		&& retain_only && osc_enable[3:0] == 4'h0) else $error("standby entry controls wrong");
	lse_keep_a: assert property (in_standby && rtc_in_use |-> osc_enable[rtc_sel_lse ? 5 : 4])
		else $error("selected slow oscillator stopped");
	all_off_a: assert property (in_standby && !rtc_in_use && !independent_watchdog_running |-> osc_enable == 6'h00)
		else $error("oscillator left running");
	wdg_clk_a: assert property ((in_stop || in_standby) && independent_watchdog_running |-> osc_enable[4])
		else $error("watchdog clock stopped");
	pin_exit_a: assert property (in_standby && |(wake_pin & ~$past(wake_pin)) |-> ##[1:4] !in_standby)
		else $error("no exit on wake pin");
	evt_exit_a: assert property (in_standby && rtc_in_use && |rtc_event |-> ##[1:5] !in_standby)
		else $error("no exit on clock event");
	quiet_stay_a: assert property ((in_standby && !rtc_in_use && external_reset_pin_n
		&& wake_pin == 0)[*4] |=> in_standby) else $error("standby left without cause");
	restart_a: assert property ($fell(in_standby) |-> (core_regulator_on && !core_reset_n)[*8])
		else $error("core not restarted");
	stop_wake_a: assert property (in_stop && |exti_line |-> ##[1:4] !in_stop)
		else $error("no exit from stop");
endmodule
bind swc_ctrl swc_chk #(.EXTI_LINES(EXTI_LINES), .WAKE_PINS(WAKE_PINS)) u_chk (.*);
`default_nettype wire

// ===== bench/standby_wakeup_controller_tb.sv
/* Self-checking bench of the standby wakeup controller.
   Assumes the controller of the core folder and its checker. */
`timescale 1ns/1ps
`default_nettype none
module standby_wakeup_controller_tb;
	logic clk = 0, rst_n = 0, stop_req = 0, standby_req = 0, vref_on = 0;
	logic rtc_in_use = 0, rtc_sel_lse = 0, independent_watchdog_running = 0;
	logic [15:0] exti_line = 0;
	logic supply_voltage_detector = 0, comp1_event = 0, comp2_event = 0, usb_wakeup = 0;
	logic [2:0] wake_pin = 0;
	logic external_reset_pin_n = 1, independent_watchdog_rst = 0;
	logic [4:0] rtc_event = 0;
	logic core_regulator_on, core_reset_n, retain_only, in_stop, in_standby;
	logic standby_flag, wake_event;
	logic [5:0] osc_enable;
	int num_errors = 0, n_compared = 0, cyc = 0;
	swc_ctrl uut (.*);
	// ------------------------------------------------------------
	// Clock, hang guard, compare and report
	// ------------------------------------------------------------
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			results;
		end
	end
	task chk(input logic [3:0] s, input logic [3:0] e);
		n_compared++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task results;
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Source k to level v; sources are levels so one helper serves all modes
	task setsrc(input int k, input logic v);
		case (k)
		0: exti_line[0] = v;
		1: exti_line[15] = v;
		2: supply_voltage_detector = v;
		3: comp1_event = v;
		4: comp2_event = v;
		5: usb_wakeup = v;
		6: wake_pin[0] = v;
		7: wake_pin[2] = v;
		8: external_reset_pin_n = !v;
		9: independent_watchdog_rst = v;
		default: rtc_event[k-10] = v;
		endcase
	endtask
	// Enter Stop or Standby, apply source k, expect exit or refusal
	task run(input bit sb, input int k, input bit ex);
		int i;
		@(negedge clk) if (sb) standby_req = 1; else stop_req = 1;
		@(negedge clk) standby_req = 0;
		stop_req = 0;
		chk(sb ? in_standby : in_stop, 1);
		if (sb) begin
			chk({core_regulator_on, retain_only, standby_flag}, 3);
			chk(osc_enable[3:0], 0);
			if (rtc_in_use) chk(osc_enable[rtc_sel_lse ? 5 : 4], 1);
			else if (!independent_watchdog_running) chk(osc_enable[5:4], 0);
		end else begin
			chk(standby_flag, 0);
		end
		if (independent_watchdog_running) chk(osc_enable[4], 1);
		setsrc(k, 1);
		for (i = 0; i < 8 && wake_event !== 1'b1; i++) @(negedge clk);
		chk(wake_event, ex);
		setsrc(k, 0);
		if (!ex) begin
			setsrc(sb ? 6 : 0, 1);
			for (i = 0; i < 8 && wake_event !== 1'b1; i++) @(negedge clk);
			setsrc(sb ? 6 : 0, 0);
		end
		chk(core_reset_n, !sb);
		for (i = 0; i < 40 && core_reset_n !== 1'b1; i++) @(negedge clk);
		chk({core_reset_n, core_regulator_on, in_standby, in_stop}, 4'hC);
		$display("test mode %0d source %0d done", sb, k);
	endtask
	initial begin
		repeat (6) @(negedge clk);
		rst_n = 1;
		repeat (2) @(negedge clk);
		rtc_in_use = 1;
		rtc_sel_lse = 1;
		independent_watchdog_running = 1;
		for (int k = 6; k < 15; k++) run(1, k, 1);
		rtc_sel_lse = 0;
		run(1, 12, 1);
		run(0, 3, 0);
		vref_on = 1;
		for (int k = 0; k < 6; k++) run(0, k, 1);
		rtc_in_use = 0;
		independent_watchdog_running = 0;
		run(1, 9, 0);
		run(1, 10, 0);
		run(1, 7, 1);
		run(1, 8, 1);
		results;
	end
endmodule
`default_nettype wire
